// ---- inc/ssdr_pkg.sv ----
// Constants, field layouts and types of the SPI register block.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
//
// How it works
// - Finished byte sets transfer-done flag, bit 7.
// - Done clears by status read, then data access.
// - Data writes ignored while done set, status unread.
// - Data write during transfer sets collision flag, bit 6.
// - Byte finishing while done set sets overrun, bit 5.
// - Status read clears overrun flag.
// - Select low in master mode sets fault, bit 4.
// - Fault clears by control access, then control write.
// - Interrupt when enabled and done, overrun or fault.
// - Status bit 3 reads zero; software writes zero.
// - Status bit 2 stops driving serial data output.
// - Status bit 1 takes select from bit 0.
// - Software select: zero selects, one deselects.
// - Master data write starts another byte exchange.
// - Finished byte copied to read buffer unless overrun; reads return it.
// - Data write loads shift register directly.
// - Data, control, status at consecutive addresses.
// - Reset clears status and upper control bits.
// - Master fault clears enable and master-select bits.
// - Enable low leaves serial pins undriven.

package ssdr_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_DATA  = 8'h21;
  localparam logic [7:0] IDX_CTRL  = 8'h22;
  localparam logic [7:0] IDX_STAT  = 8'h23;
  localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Byte framing counts
  localparam logic [3:0] LAST_SAMPLE = 4'h7;
  localparam logic [4:0] LAST_EDGE   = 5'h0F;

  // Master half-period reloads (cycles minus one) for sys_clk/4 .. /128
  localparam logic [5:0] HALF_DIV4   = 6'h01;
  localparam logic [5:0] HALF_DIV8   = 6'h03;
  localparam logic [5:0] HALF_DIV16  = 6'h07;
  localparam logic [5:0] HALF_DIV32  = 6'h0F;
  localparam logic [5:0] HALF_DIV64  = 6'h1F;
  localparam logic [5:0] HALF_DIV128 = 6'h3F;

  // Control register layout
  typedef struct packed {
    logic       irq_enable;
    logic       periph_enable;
    logic       rate_divider_sel;
    logic       master_select;
    logic       clock_idle_level;
    logic       clock_capture_phase;
    logic [1:0] rate_select;
  } ssdr_ctrl_s;

  // Status register layout
  typedef struct packed {
    logic xfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic master_fault_flag;
    logic reserved;
    logic output_disable;
    logic soft_select_mgmt;
    logic soft_select_level;
  } ssdr_stat_s;

  typedef enum logic [0:0] {SH_IDLE, SH_RUN} ssdr_shift_e;

endpackage

// ---- rtl/ssdr_sync.sv ----
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the bits are independent levels.
`timescale 1ns/1ps
`default_nettype none

module ssdr_sync #(
  parameter int unsigned     WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ---- rtl/ssdr_top.sv ----
// SPI status, flag and data register block with a compact byte shifter.
// Assumes an AXI4-Lite master on sys_clk and serial pins from outside the
// clock domain; pin tristating is resolved outside from the enables.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ssdr_top
  import ssdr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        sck_i,
  output var  logic        sck_o,
  output var  logic        sck_oe,
  input  wire logic        mosi_i,
  output var  logic        mosi_o,
  output var  logic        mosi_oe,
  input  wire logic        miso_i,
  output var  logic        miso_o,
  output var  logic        miso_oe,
  input  wire logic        ss_n_i,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] pin_s;
  logic       sck_s;
  logic       mosi_s;
  logic       miso_s;
  logic       ss_n_s;

  ssdr_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h1)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({sck_i, mosi_i, miso_i, ss_n_i}),
    .sync_out (pin_s)
  );

  assign sck_s  = pin_s[3];
  assign mosi_s = pin_s[2];
  assign miso_s = pin_s[1];
  assign ss_n_s = pin_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic        aw_held_q, aw_held_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_held_q, w_held_d;
  logic [7:0]  w_data_q, w_data_d;
  logic        w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [7:0]  rbyte_q, rbyte_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        wr_fire;
  logic        rd_fire;
  logic        w_hit;
  logic        r_hit;
  logic [7:0]  rd_val;

  ssdr_ctrl_s  ctrl_q, ctrl_d;
  ssdr_stat_s  stat_q;
  logic [7:0]  rxbuf_q, rxbuf_d;

  // Handshakes: one write and one read in flight
  assign awready = ~aw_held_q & ~bvalid_q;
  assign wready  = ~w_held_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign rd_fire = arvalid & arready;
  assign w_hit   = (aw_addr_q == ADDR_DATA) | (aw_addr_q == ADDR_CTRL) |
                   (aw_addr_q == ADDR_STAT);
  assign r_hit   = (araddr == ADDR_DATA) | (araddr == ADDR_CTRL) |
                   (araddr == ADDR_STAT);

  // Read mux; reserved bit reads zero
  always_comb begin
    rd_val = 8'h00;
    if (araddr == ADDR_DATA) begin
      rd_val = rxbuf_q;
    end else if (araddr == ADDR_CTRL) begin
      rd_val = ctrl_q;
    end else if (araddr == ADDR_STAT) begin
      rd_val = {stat_q[7:4], 1'b0, stat_q[2:0]};
    end
  end

  // Bus next state; address and data wait for each other
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rbyte_d   = rbyte_q;
    rresp_d   = rresp_q;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      w_data_d = wdata[7:0];
      w_strb_d = wstrb[0];
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rbyte_d  = rd_val;
      rresp_d  = r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rbyte_q   <= 8'h00;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rbyte_q   <= rbyte_d;
      rresp_q   <= rresp_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp  = rresp_q;
  assign rdata  = {24'h000000, rbyte_q};

  ////////////////////////////////////////////////////////////////////////////
  // Registers and flags

  ssdr_stat_s  stat_d;
  logic        armed_q, armed_d;
  logic        mf_arm_q, mf_arm_d;
  logic        ss_int;
  logic        busy;
  logic        xfer_end;
  logic [7:0]  xfer_byte;
  logic        load_tx;
  logic        data_wr, data_rd, ctrl_wr, ctrl_rd, stat_wr, stat_rd;
  logic        wr_block;
  logic        clr_seq;
  logic        done_keep;
  logic        fault;

  assign data_wr = wr_fire & w_strb_q & (aw_addr_q == ADDR_DATA);
  assign ctrl_wr = wr_fire & w_strb_q & (aw_addr_q == ADDR_CTRL);
  assign stat_wr = wr_fire & w_strb_q & (aw_addr_q == ADDR_STAT);
  assign data_rd = rd_fire & (araddr == ADDR_DATA);
  assign ctrl_rd = rd_fire & (araddr == ADDR_CTRL);
  assign stat_rd = rd_fire & (araddr == ADDR_STAT);

  // Internal select from pin or software
  assign ss_int    = stat_q.soft_select_mgmt ? stat_q.soft_select_level : ss_n_s;
  assign wr_block  = stat_q.xfer_done_flag & ~armed_q;
  assign load_tx   = data_wr & ~wr_block & ~busy & ctrl_q.periph_enable;
  assign clr_seq   = (data_rd | data_wr) & armed_q;
  assign done_keep = stat_q.xfer_done_flag & ~clr_seq;
  assign fault     = ctrl_q.master_select & ctrl_q.periph_enable & ~ss_int;

  // Flag next state; clears first so a same-cycle set wins
  always_comb begin
    stat_d   = stat_q;
    ctrl_d   = ctrl_q;
    armed_d  = armed_q;
    mf_arm_d = mf_arm_q;
    rxbuf_d  = rxbuf_q;
    if (stat_rd) begin
      armed_d             = 1'b1;
      stat_d.overrun_flag = 1'b0;
    end
    if (clr_seq) begin
      armed_d                     = 1'b0;
      stat_d.xfer_done_flag       = 1'b0;
      stat_d.write_collision_flag = 1'b0;
    end
    if (stat_wr) begin
      stat_d.output_disable    = w_data_q[2];
      stat_d.soft_select_mgmt  = w_data_q[1];
      stat_d.soft_select_level = w_data_q[0];
    end
    if (ctrl_wr) begin
      ctrl_d = w_data_q;
    end
    if (ctrl_wr && mf_arm_q) begin
      mf_arm_d                 = 1'b0;
      stat_d.master_fault_flag = 1'b0;
    end else if ((ctrl_rd || ctrl_wr) && stat_q.master_fault_flag) begin
      mf_arm_d = 1'b1;
    end
    if (data_wr && !wr_block && busy) begin
      stat_d.write_collision_flag = 1'b1;
    end
    if (xfer_end) begin
      stat_d.xfer_done_flag = 1'b1;
      if (done_keep) begin
        stat_d.overrun_flag = 1'b1;
      end else begin
        rxbuf_d = xfer_byte;
      end
    end
    if (fault) begin
      stat_d.master_fault_flag = 1'b1;
      ctrl_d.periph_enable     = 1'b0;
      ctrl_d.master_select     = 1'b0;
    end
    stat_d.reserved = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_q   <= '0;
      ctrl_q   <= CTRL_RST;
      armed_q  <= 1'b0;
      mf_arm_q <= 1'b0;
      rxbuf_q  <= DATA_RST;
    end else begin
      stat_q   <= stat_d;
      ctrl_q   <= ctrl_d;
      armed_q  <= armed_d;
      mf_arm_q <= mf_arm_d;
      rxbuf_q  <= rxbuf_d;
    end
  end

  // One request line for the three events
  assign irq = ctrl_q.irq_enable & (stat_q.xfer_done_flag | stat_q.overrun_flag |
               stat_q.master_fault_flag);

  ////////////////////////////////////////////////////////////////////////////
  // Byte shifter, MSB first

  ssdr_shift_e state_q, state_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  rx_q, rx_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [4:0]  edge_q, edge_d;
  logic [5:0]  div_q, div_d;
  logic        sck_q, sck_d;
  logic        sck_prev_q;
  logic        sck_edge;
  logic        new_lvl;
  logic        lead;
  logic        sample;
  logic        shift;
  logic        din;
  logic        slave_on;
  logic [7:0]  rx_next;
  logic [5:0]  half;

  // Half period from rate bits; unlisted codes fall back to /8
  always_comb begin
    case ({ctrl_q.rate_divider_sel, ctrl_q.rate_select})
      3'h4:    half = HALF_DIV4;
      3'h0:    half = HALF_DIV8;
      3'h1:    half = HALF_DIV16;
      3'h6:    half = HALF_DIV32;
      3'h2:    half = HALF_DIV64;
      3'h3:    half = HALF_DIV128;
      default: half = HALF_DIV8;
    endcase
  end

  assign slave_on = ctrl_q.periph_enable & ~ctrl_q.master_select & ~ss_int;
  assign busy     = (state_q == SH_RUN) | (cnt_q != 4'h0);
  assign din      = ctrl_q.master_select ? miso_s : mosi_s;
  assign rx_next  = {rx_q[6:0], din};

  // Edges: master from the divider, slave from the pin
  always_comb begin
    if (ctrl_q.master_select) begin
      sck_edge = (state_q == SH_RUN) && (div_q == 6'h00);
      new_lvl  = ~sck_q;
    end else begin
      sck_edge = slave_on && (sck_s != sck_prev_q);
      new_lvl  = sck_s;
    end
    lead   = new_lvl ^ ctrl_q.clock_idle_level;
    sample = sck_edge & (lead ^ ctrl_q.clock_capture_phase);
    // No shift before the first sample, so phase 1 keeps the MSB on the line
    shift  = sck_edge & ~(lead ^ ctrl_q.clock_capture_phase) & (cnt_q != 4'h0);
  end

  assign xfer_byte = sample ? rx_next : rx_q;
  assign xfer_end  = ctrl_q.master_select ?
                     (sck_edge && edge_q == LAST_EDGE) :
                     (sample && cnt_q == LAST_SAMPLE);

  // Shifter next state; a fault or disable abandons the byte in flight
  always_comb begin
    state_d = state_q;
    sh_d    = sh_q;
    rx_d    = rx_q;
    cnt_d   = cnt_q;
    edge_d  = edge_q;
    div_d   = div_q;
    sck_d   = sck_q;
    if (sample) begin
      rx_d  = rx_next;
      cnt_d = cnt_q + 4'h1;
    end
    if (shift) begin
      sh_d = {sh_q[6:0], 1'b0};
    end
    if (state_q == SH_RUN) begin
      div_d = (div_q == 6'h00) ? half : div_q - 6'h01;
      if (sck_edge) begin
        sck_d  = new_lvl;
        edge_d = edge_q + 5'h01;
      end
    end else begin
      sck_d = ctrl_q.clock_idle_level;
    end
    if (xfer_end) begin
      state_d = SH_IDLE;
      cnt_d   = 4'h0;
      edge_d  = 5'h00;
    end
    if (!ctrl_q.periph_enable || fault ||
        (!ctrl_q.master_select && !slave_on)) begin
      state_d = SH_IDLE;
      cnt_d   = 4'h0;
      edge_d  = 5'h00;
    end
    if (load_tx) begin
      sh_d  = w_data_q;
      cnt_d = 4'h0;
      if (ctrl_q.master_select) begin
        state_d = SH_RUN;
        div_d   = half;
        edge_d  = 5'h00;
        sck_d   = ctrl_q.clock_idle_level;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q    <= SH_IDLE;
      sh_q       <= SHIFT_RST;
      rx_q       <= SHIFT_RST;
      cnt_q      <= 4'h0;
      edge_q     <= 5'h00;
      div_q      <= 6'h00;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      sh_q       <= sh_d;
      rx_q       <= rx_d;
      cnt_q      <= cnt_d;
      edge_q     <= edge_d;
      div_q      <= div_d;
      sck_q      <= sck_d;
      sck_prev_q <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; nothing driven while disabled

  assign sck_o   = sck_q;
  assign mosi_o  = sh_q[7];
  assign miso_o  = sh_q[7];
  assign sck_oe  = ctrl_q.periph_enable & ctrl_q.master_select;
  assign mosi_oe = ctrl_q.periph_enable & ctrl_q.master_select &
                   ~stat_q.output_disable;
  assign miso_oe = slave_on & ~stat_q.output_disable;

endmodule

`default_nettype wire

// ---- tb/ssdr_top_props.sv ----
// Checker for the SPI register block: bus answers, pin enables, reset.
// Bound into ssdr_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ssdr_top_props
  import ssdr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        ss_n_i,
  input wire logic        irq
);
  logic [7:0] rd_addr_q;
  logic [7:0] rd_addr_d;
  logic       mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Read address of the answer in flight
  always_comb begin
    rd_addr_d = rd_addr_q;
    if (arvalid && arready) begin
      rd_addr_d = araddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_addr_q <= rd_addr_d;
  end

  assign mapped = rd_addr_q inside {ADDR_DATA, ADDR_CTRL, ADDR_STAT};

  ////////////////////////////////////////////////////////////////////////////
  // One clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // Master with select low past the synchroniser
  sequence s_fault_pin;
    (sck_oe && !ss_n_i) [*2];
  endsequence

  AST_READ_ANSWER: assert property (s_ar_taken |=> rvalid && !arready)
    else $error("read not answered in one cycle");
  AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed early");
  AST_WRITE_ANSWER: assert property (s_wr_taken |=> !bvalid ##1 bvalid)
    else $error("write answer not on second cycle");
  AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer changed early");
  AST_WR_STALL: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  AST_RESERVED_ZERO: assert property (
    rvalid && rd_addr_q == ADDR_STAT |-> rdata[3] == 1'b0 && rdata[31:8] == 24'h0)
    else $error("reserved bit read as one");
  AST_DECODE: assert property (
    rvalid |-> rresp == (mapped ? RESP_OKAY : RESP_SLVERR) && (mapped || rdata == 32'h0))
    else $error("decode answer wrong");
  AST_MOSI_MASTER: assert property (mosi_oe |-> sck_oe)
    else $error("data out driven off master mode");
  AST_ONE_DRIVER: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave out driven as master");
  AST_FAULT_DROP: assert property (s_fault_pin |-> ##[0:4] !sck_oe)
    else $error("master kept pins after fault");
  AST_RESET_QUIET: assert property (
    $rose(rst_n) |-> !irq && !sck_oe && !mosi_oe && !miso_oe && !bvalid && !rvalid)
    else $error("outputs active after reset");
endmodule

bind ssdr_top ssdr_top_props u_props (
  .sys_clk, .rst_n, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .sck_oe, .mosi_oe, .miso_oe, .ss_n_i, .irq);

`default_nettype wire

// ---- tb/ssdr_spi_peer.sv ----
// Behavioural SPI peer: mode-0 slave, or mode-0 master on request.
// Assumes the bench resolves each shared line.
`timescale 1ns/1ps
`default_nettype none

module ssdr_spi_peer (
  input  wire logic       sck_w,
  input  wire logic       mosi_w,
  input  wire logic       miso_w,
  input  wire logic       sel_n,
  input  wire logic       go,
  input  wire logic [7:0] tx,
  output var  logic       sck_m,
  output var  logic       mosi_m,
  output var  logic       ss_m_n,
  output var  logic       miso_s,
  output var  logic       busy,
  output var  logic [7:0] rx
);
  logic [7:0] sh;

  // Idle: clock still and low, select high
  initial begin
    {sck_m, mosi_m, miso_s, busy, rx, sh} = '0;
    ss_m_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave role: first bit on select, next ones on falling edges
  always @(negedge sel_n) begin
    sh = tx;
    miso_s = tx[7];
  end
  always @(negedge sck_w) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso_s = sh[7];
  end
  // Released line flips so a stale bit is not read
  always @(posedge sel_n) miso_s = ~miso_s;

  // Both roles sample on the rising edge
  always @(posedge sck_w) if (!sel_n || !ss_m_n) begin
    rx <= {rx[6:0], ss_m_n ? mosi_w : miso_w};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master role: one byte MSB first, 400 ns clock only inside the frame
  always @(posedge go) begin
    busy = 1'b1;
    sh = tx;
    ss_m_n = 1'b0;
    mosi_m = sh[7];
    for (int i = 0; i < 8; i++) begin
      #200 sck_m = 1'b1;
      #200 sck_m = 1'b0;
      sh = {sh[6:0], 1'b0};
      mosi_m = sh[7];
    end
    #200 ss_m_n = 1'b1;
    mosi_m = ~mosi_m;
    busy = 1'b0;
  end
endmodule

`default_nettype wire

// ---- tb/ssdr_top_bench.sv ----
// Self-checking bench for the SPI status and data register block.
// Assumes ssdr_top, its package, the peer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module ssdr_top_bench
  import ssdr_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        ss_b = 1'b1;
  logic        slv_sel_n = 1'b1;
  logic        p_go = 1'b0;
  logic [7:0]  p_tx = 8'h00;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        sck_m, mosi_m, ss_m_n, miso_s, p_busy;
  logic [7:0]  p_rx;
  int          n_fail = 0;
  int          compares = 0;
  int          oe_cnt = 0;
  // Shared lines: whoever enables its driver owns the wire
  wire         sck_w = sck_oe ? sck_o : sck_m;
  wire         mosi_w = mosi_oe ? mosi_o : mosi_m;
  wire         miso_w = miso_oe ? miso_o : miso_s;
  wire         ss_w = ss_b & ss_m_n;

  ssdr_top dut (.sys_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe,
    .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i(ss_w), .irq);
  ssdr_spi_peer peer (.sck_w, .mosi_w, .miso_w, .sel_n(slv_sel_n), .go(p_go), .tx(p_tx),
    .sck_m, .mosi_m, .ss_m_n, .miso_s, .busy(p_busy), .rx(p_rx));

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock; count cycles with the slave output driven
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (miso_oe === 1'b1) oe_cnt <= oe_cnt + 1;

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: offer, drop each channel when taken, wait for the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    int k = 0;
    r = 2'b11;
    @(posedge sys_clk);
    {awaddr, wdata, wstrb} <= {a, 24'h0, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    while (r === 2'b11 && k < 100) begin
      @(posedge sys_clk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k = 0;
    r = 2'b11;
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (r === 2'b11 && k < 100) begin
      @(posedge sys_clk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] r;
    wr(a, v, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask

  // Bounded waits for the interrupt and for a peer frame
  task automatic wirq();
    for (int k = 0; k < 600 && irq !== 1'b1; k++) @(posedge sys_clk);
  endtask

  task automatic frame(input logic [7:0] b);
    @(posedge sys_clk);
    p_tx <= b;
    p_go <= 1'b1;
    @(posedge sys_clk);
    p_go <= 1'b0;
    for (int k = 0; k < 200 && p_busy === 1'b1; k++) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("stat rst", ADDR_STAT, 32'h0);
    rd(ADDR_CTRL, d, r);
    chk("ctrl rst", d & 32'hF0, 32'h0);
    rd(8'h80, d, r);
    chk("bad read", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h90, 8'hFF, r);
    chk("bad write", r, RESP_SLVERR);
    // Master byte, blocked write, masking, two-step clear
    p_tx <= 8'h3C;
    slv_sel_n <= 1'b0;
    wr8(ADDR_CTRL, 8'hD0);
    rdc("ctrl", ADDR_CTRL, 32'hD0);
    wr8(ADDR_DATA, 8'hA5);
    wirq();
    chk("done irq", irq, 1);
    wr8(ADDR_DATA, 8'hFF);
    repeat (100) @(posedge sys_clk);
    chk("peer byte", p_rx, 8'hA5);
    rdc("buf", ADDR_DATA, 8'h3C);
    wr8(ADDR_CTRL, 8'h50);
    chk("irq masked", irq, 0);
    wr8(ADDR_CTRL, 8'hD0);
    rdc("done held", ADDR_STAT, 8'h80);
    rdc("buf again", ADDR_DATA, 8'h3C);
    rdc("done clr", ADDR_STAT, 8'h0);
    // Write while shifting collides
    slv_sel_n <= 1'b1;
    @(posedge sys_clk);
    p_tx <= 8'h69;
    slv_sel_n <= 1'b0;
    wr8(ADDR_DATA, 8'h5A);
    wr8(ADDR_DATA, 8'hFF);
    wirq();
    chk("peer first", p_rx, 8'h5A);
    rdc("coll", ADDR_STAT, 8'hC0);
    rdc("buf 2", ADDR_DATA, 8'h69);
    rdc("coll clr", ADDR_STAT, 8'h0);
    // Select pulled low while master
    ss_b <= 1'b0;
    wirq();
    ss_b <= 1'b1;
    chk("fault irq", irq, 1);
    chk("pins off", {sck_oe, mosi_oe}, 0);
    rdc("fault", ADDR_STAT, 8'h10);
    rdc("ctrl fault", ADDR_CTRL, 8'h80);
    wr8(ADDR_CTRL, 8'hC0);
    rdc("fault clr", ADDR_STAT, 8'h0);
    // Slave mode: reply, overrun, output disable
    slv_sel_n <= 1'b1;
    wr8(ADDR_DATA, 8'h96);
    d = oe_cnt;
    frame(8'h81);
    wirq();
    chk("slave drove", oe_cnt > d, 1);
    chk("master got", p_rx, 8'h96);
    frame(8'h42);
    rdc("ovr", ADDR_STAT, 8'hA0);
    rdc("ovr clr", ADDR_STAT, 8'h80);
    rdc("kept byte", ADDR_DATA, 8'h81);
    rdc("slave clr", ADDR_STAT, 8'h0);
    wr8(ADDR_STAT, 8'h04);
    d = oe_cnt;
    frame(8'h33);
    wirq();
    chk("od off", oe_cnt - d, 0);
    rdc("od kept", ADDR_STAT, 8'h84);
    rdc("buf 3", ADDR_DATA, 8'h33);
    // Soft select overrides the pin
    wr8(ADDR_STAT, 8'h02);
    chk("soft select", miso_oe, 1);
    wr8(ADDR_STAT, 8'h03);
    ss_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("soft desel", miso_oe, 0);
    ss_b <= 1'b1;
    tally_and_finish();
  end

  // Watchdog: the tests need about 600 cycles
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
